/* File: src/nv_host.sv */
// host controller driving a nonvolatile sram through its strobe pins
// Behaviour
// [RL1] write strobe held high during every read, command reads included
// [RL2] store/busy line kept released during ordinary reads and writes
// [RL3] device floats outputs if write strobe low when select falls
// [RL4] device restores array within 20 ms after power up
// [RL5] device skips saves when nothing was written since last one
// [RL6] device accepts in-flight write 25 ns after store starts
// [RL7] device ignores accesses during store, recall or low supply
// [RL8] command steps are select-timed read cycles
// [RL9] exactly six ordered command reads with write strobe high
// [RL10] data of sixth command read is discarded
// [RL11] device acts on command within 100 us
// [RL12] store and recall extend lockout beyond base latency
// [RL13] store with nothing pending ends quickly, outputs back
// [RL14] hardware store request drives busy line low at least 15 ns
// [RL15] device drives busy line high 500 ns after store
// [RL16] reads drive only enabled byte lanes
// [RL17] writes change only enabled byte lanes
// [RL18] data floats while deselected or lanes disabled
// [RL19] host waits for busy line release before new access
`timescale 1ns/100ps
`include "nv_host_consts.svh"
module nv_host #(
    parameter int AW = 18,
    parameter int DW = 16,
    parameter int RECALL_CYC = `POWERUP_RECALL_CYC,
    parameter int CMD_CYC = `SOFT_SEQ_CYC,
    parameter int STORE_WAIT_CYC = `STORE_CYC
) (
    input wire logic clock, // 10 mhz clock
    input wire logic nrst, // async reset, active low
    input wire logic req_valid, // request present
    output logic req_ready, // request taken
    input wire nv_host_pkg::op_t req_op, // operation
    input wire logic [AW-1:0] req_addr, // word address
    input wire logic [DW-1:0] req_wdata, // write data
    input wire logic [1:0] req_lanes, // bit1 upper, bit0 lower lane
    output logic [DW-1:0] rsp_rdata, // read data
    output logic rsp_valid, // one-cycle completion pulse
    output logic ce_n, // chip select
    output logic we_n, // write strobe
    output logic oe_n, // output enable
    output logic upper_byte_lane_n, // upper lane enable
    output logic lower_byte_lane_n, // lower lane enable
    output logic [AW-1:0] addr, // address pins
    output logic [DW-1:0] dq_out, // data driven
    output logic [1:0] dq_oe, // per lane drive enable
    input wire logic [DW-1:0] dq_in, // data sampled
    output logic store_request_busy_n_out, // busy line drive value
    output logic store_request_busy_n_oe, // busy line drive enable
    input wire logic store_request_busy_n_in // busy line level
);
    import nv_host_pkg::*;
    logic rst_s1_reg, rst_n_reg;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_s1_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n_reg <= rst_s1_reg;
        end
    end
    state_t state_reg, state_next;
    op_t op_reg;
    logic [31:0] cnt_reg, cnt_next;
    logic [2:0] step_reg;
    logic [AW-1:0] addr_reg;
    logic [DW-1:0] wdata_reg;
    logic [1:0] lanes_reg;
    logic [AW-1:0] cmd_addr;
    wire busy_low = !store_request_busy_n_in;
    wire is_write = (op_reg == op_write);
    wire is_soft = (op_reg == op_soft_cmd);
    wire cnt_zero = (cnt_reg == 32'h0);
    wire in_access = (state_reg == st_setup) || (state_reg == st_strobe);
    wire last_step = (step_reg == 3'(`SOFT_SEQ_LEN - 1));
    // [RL19] no new access while busy low
    wire can_take = (state_reg == st_idle) && !busy_low;
    assign req_ready = can_take;
    // the rom output is registered, so feed it the next step or the address lags a step
    wire [2:0] step_next = (state_reg == st_idle && req_valid && can_take) ? 3'h0 :
        (state_reg == st_done && is_soft && !last_step) ? step_reg + 3'h1 : step_reg;
    // [RL9] command addresses in table order
    cmd_addr_rom #(.AW(AW)) rom_i (
        .clock(clock),
        .index(step_next),
        .addr(cmd_addr)
    );
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_zero ? 32'h0 : cnt_reg - 32'h1;
        case (state_reg)
            // [RL4] wait out power-up recall
            st_wake: if (cnt_zero) state_next = st_idle;
            st_idle: begin
                if (req_valid && can_take) begin
                    if (req_op == op_hw_store) begin
                        state_next = st_store_pulse;
                        cnt_next = 32'(`HW_STORE_PULSE_CYC);
                    end else begin
                        state_next = st_setup;
                    end
                end
            end
            st_setup: begin
                state_next = st_strobe;
                cnt_next = 32'(`ACCESS_CYC);
            end
            st_strobe: if (cnt_zero) state_next = st_done;
            st_done: begin
                // [RL9] six steps back to back
                if (is_soft && !last_step) begin
                    state_next = st_setup;
                end else if (is_soft) begin
                    // [RL11] allow command processing time
                    state_next = st_soft_wait;
                    cnt_next = 32'(CMD_CYC);
                end else begin
                    state_next = st_idle;
                end
            end
            // [RL14] hold busy line low
            st_store_pulse: if (cnt_zero) state_next = st_store_wait;
            st_store_wait: if (!busy_low) state_next = st_idle;
            // [RL12] store or recall lockout beyond base latency
            st_soft_wait: begin
                if (cnt_zero && !busy_low) begin
                    state_next = st_store_wait;
                    cnt_next = 32'(STORE_WAIT_CYC);
                end
            end
            default: state_next = st_idle;
        endcase
    end
    always_ff @(posedge clock or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= st_wake;
            cnt_reg <= 32'(RECALL_CYC);
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end
    always_ff @(posedge clock or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            op_reg <= op_read;
            addr_reg <= '0;
            wdata_reg <= '0;
            lanes_reg <= 2'h0;
            step_reg <= 3'h0;
        end else if (state_reg == st_idle && req_valid && can_take) begin
            op_reg <= req_op;
            addr_reg <= req_addr;
            wdata_reg <= req_wdata;
            // command reads use both lanes
            lanes_reg <= (req_op == op_soft_cmd) ? 2'h3 : req_lanes;
            step_reg <= 3'h0;
        end else if (state_reg == st_done && is_soft && !last_step) begin
            step_reg <= step_reg + 3'h1;
        end
    end
    // [RL8] command steps use the rom address
    wire [AW-1:0] addr_sel = is_soft ? cmd_addr : addr_reg;
    // [RL3] write strobe falls only after select is low
    wire we_sel = (state_reg == st_strobe) && is_write;
    // [RL16] lane pins mirror requested lanes, both lanes for command reads
    wire [1:0] lane_sel = in_access ? lanes_reg : 2'h0;
    always_ff @(posedge clock or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ce_n <= 1'b1;
            we_n <= 1'b1;
            oe_n <= 1'b1;
            upper_byte_lane_n <= 1'b1;
            lower_byte_lane_n <= 1'b1;
            addr <= '0;
        end else begin
            ce_n <= !in_access;
            // [RL1] write strobe stays high for reads
            we_n <= !we_sel;
            oe_n <= !(in_access && !is_write);
            upper_byte_lane_n <= !lane_sel[1];
            lower_byte_lane_n <= !lane_sel[0];
            addr <= addr_sel;
        end
    end
    // [RL17] drive only the lanes being written
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : lane_g
            always_ff @(posedge clock or negedge rst_n_reg) begin
                if (!rst_n_reg) begin
                    dq_oe[g] <= 1'b0;
                    dq_out[g*8 +: 8] <= 8'h00;
                end else begin
                    dq_oe[g] <= in_access && is_write && lanes_reg[g];
                    dq_out[g*8 +: 8] <= wdata_reg[g*8 +: 8];
                end
            end
        end
    endgenerate
    // sample at end of strobe; pins were set a cycle earlier so data has settled
    wire sample = (state_reg == st_done) && !is_write;
    always_ff @(posedge clock or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            rsp_rdata <= '0;
            rsp_valid <= 1'b0;
        end else begin
            // [RL10] data of all six command reads dropped
            if (sample && !is_soft) begin
                rsp_rdata <= dq_in;
            end
            rsp_valid <= (state_next == st_idle) && (state_reg != st_idle)
                && (state_reg != st_wake);
        end
    end
    // [RL2] busy line driven only for a store request
    always_ff @(posedge clock or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            store_request_busy_n_oe <= 1'b0;
        end else begin
            store_request_busy_n_oe <= (state_next == st_store_pulse);
        end
    end
    assign store_request_busy_n_out = 1'b0;
endmodule : nv_host

/* File: src/nv_host_consts.svh */
// timing counts and the command sequence length for the nonvolatile sram host controller
`ifndef NV_HOST_CONSTS_SVH
`define NV_HOST_CONSTS_SVH
`define CLK_PERIOD_NS 100
`define HW_STORE_PULSE_NS 15
`define HW_STORE_PULSE_CYC ((`HW_STORE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUSY_HIGH_NS 500
`define BUSY_HIGH_CYC ((`BUSY_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POWERUP_RECALL_MS 20
`define POWERUP_RECALL_CYC (`POWERUP_RECALL_MS * 1000000 / `CLK_PERIOD_NS)
`define SOFT_SEQ_US 100
`define SOFT_SEQ_CYC (`SOFT_SEQ_US * 1000 / `CLK_PERIOD_NS)
`define STORE_MS 8
`define STORE_CYC (`STORE_MS * 1000000 / `CLK_PERIOD_NS)
`define SOFT_SEQ_LEN 6
`define ACCESS_CYC 1
`endif

/* File: src/nv_host_pkg.sv */
// types for the nonvolatile sram host controller
package nv_host_pkg;
    typedef enum logic [1:0] {
        op_read = 2'h0,
        op_write = 2'h1,
        op_hw_store = 2'h2,
        op_soft_cmd = 2'h3
    } op_t;
    typedef enum logic [7:0] {
        st_wake = 8'h01,
        st_idle = 8'h02,
        st_setup = 8'h04,
        st_strobe = 8'h08,
        st_done = 8'h10,
        st_store_pulse = 8'h20,
        st_store_wait = 8'h40,
        st_soft_wait = 8'h80
    } state_t;
endpackage : nv_host_pkg

/* File: src/cmd_addr_rom.sv */
// registered table of the six software command addresses
`timescale 1ns/100ps
module cmd_addr_rom #(
    parameter int AW = 18,
    parameter logic [AW-1:0] A0 = 18'h0e38,
    parameter logic [AW-1:0] A1 = 18'h31c7,
    parameter logic [AW-1:0] A2 = 18'h03e0,
    parameter logic [AW-1:0] A3 = 18'h3c1f,
    parameter logic [AW-1:0] A4 = 18'h303f,
    parameter logic [AW-1:0] A5 = 18'h0fc0
) (
    input wire logic clock, // system clock
    input wire logic [2:0] index, // step of the sequence
    output logic [AW-1:0] addr // registered address
);
    wire [AW-1:0] table_sel = (index == 3'h0) ? A0 : (index == 3'h1) ? A1 :
        (index == 3'h2) ? A2 : (index == 3'h3) ? A3 : (index == 3'h4) ? A4 : A5;
    always_ff @(posedge clock) begin
        addr <= table_sel;
    end
endmodule : cmd_addr_rom

/* File: verif/nv_host_props.sv */
// concurrent checks on the host controller pins
`timescale 1ns/100ps
module nv_host_props
import nv_host_pkg::*;
(
    input wire logic clock, // clock
    input wire logic nrst, // reset
    input wire logic req_valid, // request
    input wire logic req_ready, // taken
    input wire nv_host_pkg::op_t req_op, // op
    input wire logic rsp_valid, // done
    input wire logic ce_n, // select
    input wire logic we_n, // write strobe
    input wire logic oe_n, // output enable
    input wire logic upper_byte_lane_n, // upper lane
    input wire logic lower_byte_lane_n, // lower lane
    input wire logic [1:0] dq_oe, // lane drive
    input wire logic [17:0] addr, // address pins
    input wire logic store_request_busy_n_out, // busy drive value
    input wire logic store_request_busy_n_oe, // busy drive enable
    input wire logic store_request_busy_n_in // busy level
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    a_read_we_high: assert property (!ce_n && !oe_n |-> we_n)
        else $error("write strobe low in read");
    a_busy_idle_access: assert property (!ce_n |-> !store_request_busy_n_oe)
        else $error("busy driven during access");
    a_store_drive_low: assert property ($rose(store_request_busy_n_oe) |->
        ce_n && !store_request_busy_n_out) else $error("bad store pulse");
    a_ready_busy_wait: assert property (!store_request_busy_n_in |-> !req_ready)
        else $error("ready while busy low");
    a_read_no_drive: assert property (!oe_n |-> dq_oe == 2'h0)
        else $error("host drives data in read");
    a_write_after_select: assert property ($fell(we_n) |-> !$past(ce_n))
        else $error("write strobe before select");
    a_lane_drive: assert property (dq_oe != 2'h0 |-> !we_n || !ce_n)
        else $error("data driven outside write");
    a_select_width: assert property ($fell(ce_n) |=> !ce_n)
        else $error("select pulse too short");
    a_addr_hold: assert property (!ce_n |=> ce_n || $stable(addr))
        else $error("address moved while selected");
    a_rsp_timing: assert property (req_valid && req_ready &&
        (req_op == op_read || req_op == op_write) |-> ##[4:5] rsp_valid)
        else $error("access answer late");
endmodule : nv_host_props
bind nv_host nv_host_props u_props (.*);

/* File: verif/nv_sram_model.sv */
// behavioural model of the nonvolatile sram seen from its pins
`timescale 1ns/100ps
module nv_sram_model (
    input wire logic clock, // clock
    input wire logic ce_n, // select
    input wire logic we_n, // write strobe
    input wire logic oe_n, // output enable
    input wire logic ub_n, // upper lane
    input wire logic lb_n, // lower lane
    input wire logic [17:0] addr, // address
    input wire logic [15:0] dq_out, // host data
    output logic [15:0] dq_in, // device data
    input wire logic busy_line, // resolved busy level
    output logic busy_drv, // device drives busy
    output logic busy_val // busy drive value
);
    logic [15:0] mem [64];
    // power-up recall keeps the port locked for the first cycles
    logic [3:0] bcnt = 4'h8;
    logic dirty = 1'b0;
    logic tog = 1'b0;
    logic rd;
    logic locked;
    initial foreach (mem[i]) mem[i] = 16'h0;
    // locked while the save runs; the high drive after it already allows access
    assign locked = bcnt > 4'h5;
    // only enabled lanes driven, else toggling; no data while we_n low
    assign rd = !ce_n && we_n && !oe_n && !locked;
    assign dq_in[7:0] = (rd && !lb_n) ? mem[addr[5:0]][7:0] : {4{tog, ~tog}};
    assign dq_in[15:8] = (rd && !ub_n) ? mem[addr[5:0]][15:8] : {4{~tog, tog}};
    // low during store, then high 500 ns
    assign busy_drv = bcnt != 4'h0;
    assign busy_val = bcnt <= 4'h5;
    always @(posedge clock) begin
        tog <= ~tog;
        // writes ignored while locked; one in the starting cycle still lands
        if (!ce_n && !we_n && !locked) begin
            if (!lb_n) mem[addr[5:0]][7:0] <= dq_out[7:0];
            if (!ub_n) mem[addr[5:0]][15:8] <= dq_out[15:8];
            dirty <= 1'b1;
        end
        if (bcnt != 4'h0) bcnt <= bcnt - 4'h1;
        else if (!busy_line && dirty) begin
            bcnt <= 4'hf;
            dirty <= 1'b0;
        end
    end
endmodule : nv_sram_model

/* File: verif/nv_sram_port_store_recall_bench.sv */
// self-checking bench for the host controller
`timescale 1ns/100ps
module nv_sram_port_store_recall_bench;
    import nv_host_pkg::*;
    logic clock = 1'b0, nrst = 1'b0, req_valid = 1'b0, req_ready, rsp_valid;
    op_t req_op = op_read;
    logic [17:0] req_addr = 18'h0, addr;
    logic [15:0] req_wdata = 16'h0, rsp_rdata, dq_out, dq_in;
    logic [1:0] req_lanes = 2'h3, dq_oe;
    logic ce_n, we_n, oe_n, ub_n, lb_n, b_out, b_oe, b_line, m_drv, m_val;
    int n_fail = 0, tests_run = 0, n_ce = 0, n_we = 0, c1, c2;
    always #50 clock = ~clock;
    assign b_line = (b_oe && !b_out) ? 1'b0 : (m_drv ? m_val : 1'b1);
    always @(negedge ce_n) n_ce++;
    always @(negedge we_n) n_we++;
    nv_host #(.RECALL_CYC(5), .CMD_CYC(5), .STORE_WAIT_CYC(5)) dut_u (.clock(clock),
        .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_lanes(req_lanes),
        .rsp_rdata(rsp_rdata), .rsp_valid(rsp_valid), .ce_n(ce_n), .we_n(we_n),
        .oe_n(oe_n), .upper_byte_lane_n(ub_n), .lower_byte_lane_n(lb_n), .addr(addr),
        .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .store_request_busy_n_out(b_out),
        .store_request_busy_n_oe(b_oe), .store_request_busy_n_in(b_line));
    nv_sram_model mdl_u (.clock(clock), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
        .ub_n(ub_n), .lb_n(lb_n), .addr(addr), .dq_out(dq_out), .dq_in(dq_in),
        .busy_line(b_line), .busy_drv(m_drv), .busy_val(m_val));
    task automatic print_verdict();
        if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] %0t got %h want %h", $time, s, e);
        end
    endtask : chk
    task automatic do_op(input op_t op, input logic [17:0] a, input logic [15:0] d,
        input logic [1:0] ln, output int cyc);
        @(negedge clock);
        req_op = op;
        req_addr = a;
        req_wdata = d;
        req_lanes = ln;
        req_valid = 1'b1;
        for (cyc = 0; cyc < 200 && req_ready !== 1'b1; cyc++) @(negedge clock);
        chk({15'h0, cyc < 200}, 16'h1);
        @(negedge clock);
        req_valid = 1'b0;
        for (cyc = 0; cyc < 200 && rsp_valid !== 1'b1; cyc++) @(negedge clock);
        chk({15'h0, cyc < 200}, 16'h1);
    endtask : do_op
    task automatic t_lanes();
        do_op(op_write, 18'h3, 16'hbeef, 2'h3, c1);
        do_op(op_write, 18'h3, 16'h1234, 2'h1, c1);
        do_op(op_read, 18'h3, 16'h0, 2'h3, c1);
        chk(rsp_rdata, 16'hbe34);
        do_op(op_read, 18'h3, 16'h0, 2'h2, c1);
        chk({8'h0, rsp_rdata[15:8]}, 16'h00be);
    endtask : t_lanes
    task automatic t_store();
        do_op(op_hw_store, 18'h0, 16'h0, 2'h3, c1);
        do_op(op_hw_store, 18'h0, 16'h0, 2'h3, c2);
        chk({15'h0, c1 > c2 + 4}, 16'h1);
        do_op(op_read, 18'h3, 16'h0, 2'h3, c1);
        chk(rsp_rdata, 16'hbe34);
    endtask : t_store
    task automatic t_soft();
        n_ce = 0;
        n_we = 0;
        do_op(op_soft_cmd, 18'h0, 16'h0, 2'h3, c1);
        chk({15'h0, c1 < 60}, 16'h1);
        chk(16'(n_ce), 16'h6);
        chk(16'(n_we), 16'h0);
    endtask : t_soft
    initial begin
        #200000;
        n_fail++;
        print_verdict();
    end
    initial begin
        repeat (10) @(negedge clock);
        nrst = 1'b1;
        t_lanes();
        t_store();
        t_soft();
        print_verdict();
    end
endmodule : nv_sram_port_store_recall_bench
